// ===== hw/fcs_defs.svh
// register indices, field positions, reset values and timing figures of the flash register bank
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FCS_IDX_TIMING_DIVIDER 4'h0
`define FCS_IDX_SECURITY_STATE 4'h1
`define FCS_IDX_FACTORY_TEST 4'h2
`define FCS_IDX_MODULE_CONFIG 4'h3
`define FCS_IDX_SECTOR_PROT 4'h4
`define FCS_IDX_COMMAND_STATUS 4'h5
`define FCS_IDX_COMMAND_CODE 4'h6
`define FCS_IDX_NV_CONTROL 4'h7
`define FCS_IDX_ADDR_HIGH 4'h8
`define FCS_IDX_ADDR_LOW 4'h9
`define FCS_IDX_DATA_HIGH 4'hA
`define FCS_IDX_DATA_LOW 4'hB
`define FCS_IDX_BANKED_FIRST 4'h4
`define FCS_IDX_BANKED_LAST 4'hB

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FCS_DIV_LOADED_BIT 7
`define FCS_DIV_PRESCALE_BIT 6
`define FCS_SEC_KEY_HI 7
`define FCS_SEC_KEY_LO 6
`define FCS_SEC_FIELD_HI 1
`define FCS_SEC_FIELD_LO 0
`define FCS_CFG_CMD_EMPTY_IE_BIT 7
`define FCS_CFG_CMD_DONE_IE_BIT 6
`define FCS_CFG_KEY_ACCESS_BIT 5
`define FCS_CFG_BANK_BIT 0

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define FCS_KEY_ENABLED 2'h2
`define FCS_SEC_UNSECURED 2'h2
`define FCS_SECURITY_RESET 8'hFF
`define FCS_PROT_RESET 8'hFF
`define FCS_PRESCALE_LAST 3'h7
`define FCS_MAX_RATIO 10'h200

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FCS_PCLK_PERIOD_NS 100

`endif

// ===== hw/fcs_pkg.sv
// types of the flash register bank
package fcs_pkg;

   // ----------------------------------------------------------------
   // whole state of the register bank
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] osc_sync;
      logic osc_level;
      logic [2:0] pre_cnt;
      logic [5:0] div_cnt;
      logic tick;
      logic divider_loaded_flag;
      logic prescale_by_eight;
      logic [5:0] divider_value;
      logic load_done;
      logic [7:0] security_state;
      logic cmd_empty_ie;
      logic cmd_done_ie;
      logic key_write_access;
      logic bank_select;
      logic [1:0][7:0] sector_protection;
      logic [1:0][7:0] command_code;
      logic [31:0] prdata;
   } fcs_state_t;

endpackage

// ===== hw/fcs_regs.sv
// flash clock divider, security and configuration register bank behind an APB slave
`timescale 1ns/1ps
`include "fcs_defs.svh"

// Function
// (RQ1) divider loaded flag reads 0 until first divider write, then 1; never writable
// (RQ2) divider register fully readable; low seven bits take only the first write
// (RQ3) prescale bit 0 feeds oscillator straight in; 1 divides it by eight first
// (RQ4) software picks prescale and divider for a 150 to 200 kHz timing clock
// (RQ5) total division ratio reaches at most 512
// (RQ6) divider register is one unbanked copy and times program and erase
// (RQ7) security register is one unbanked, readable copy; writes do nothing
// (RQ8) security register loads from the non-volatile byte during reset sequence
// (RQ9) backdoor key access enabled only for key field value 10
// (RQ10) security field value 10 means unsecured; every other value means secured
// (RQ11) successful backdoor unlock forces security field to 10
// (RQ12) software leaves the four reserved non-volatile security bits erased at 1
// (RQ13) value 01 is the preferred, not mandatory, disable and secure code
// (RQ14) registers at indices 4 to B exist once per block, chosen by bank select; only 4 and 6 are implemented, banked, the rest read 0
// (RQ15) key write access bit writable only while backdoor key access is enabled
// (RQ16) division ratio is prescale factor times divider value plus one
module fcs_regs #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk, // bus clock, 10 MHz
   input wire logic presetn, // asynchronous reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction, 1 = write
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on misaligned address or index above F
   input wire logic osc_clk, // oscillator clock, sampled as a pin
   input wire logic [7:0] nv_security_byte, // non-volatile security byte
   input wire logic backdoor_unlock, // pulse: backdoor key compare passed
   output logic flash_timing_tick, // one pulse per flash timing clock period
   output logic divider_loaded, // divider has been written since reset
   output logic backdoor_enabled, // backdoor key access allowed
   output logic security_unsecured, // module is unsecured
   output logic key_write_access, // array writes are backdoor keys
   output logic cmd_empty_irq_en, // command buffer empty interrupt enable
   output logic cmd_done_irq_en, // command complete interrupt enable
   output logic bank_select // active banked register copy
);

   fcs_pkg::fcs_state_t cur;
   fcs_pkg::fcs_state_t next_cur;

   logic bad_addr;
   logic [3:0] idx;
   logic setup_phase;
   logic access_wr;
   logic wr_divider;
   logic wr_security;
   logic wr_config;
   logic wr_prot;
   logic wr_cmd;
   logic key_on;
   logic osc_edge;
   logic pre_done;
   logic [7:0] rd_byte;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   assign idx = paddr[5:2];
   assign bad_addr = (paddr[1:0] != 2'h0) || (paddr[ADDR_W-1:6] != '0);
   assign setup_phase = psel && !penable;
   assign access_wr = psel && penable && pwrite && !bad_addr;
   // (RQ6) unbanked divider decode
   assign wr_divider = access_wr && (idx == `FCS_IDX_TIMING_DIVIDER);
   assign wr_security = access_wr && (idx == `FCS_IDX_SECURITY_STATE);
   assign wr_config = access_wr && (idx == `FCS_IDX_MODULE_CONFIG);
   assign wr_prot = access_wr && (idx == `FCS_IDX_SECTOR_PROT);
   assign wr_cmd = access_wr && (idx == `FCS_IDX_COMMAND_CODE);

   // read data is latched in setup, so the access phase never waits
   assign pready = 1'b1;
   assign pslverr = psel && penable && bad_addr;
   assign prdata = cur.prdata;

   // (RQ9) key field decode
   assign key_on = (cur.security_state[`FCS_SEC_KEY_HI:`FCS_SEC_KEY_LO] == `FCS_KEY_ENABLED);

   // ----------------------------------------------------------------
   // oscillator edge, counted once second and third stage agree
   // ----------------------------------------------------------------
   logic next_level;
   always_comb
   begin
      next_level = cur.osc_level;
      if (cur.osc_sync[1] == cur.osc_sync[2])
      begin
         next_level = cur.osc_sync[2];
      end
   end
   assign osc_edge = next_level && !cur.osc_level;
   // (RQ3) prescale selects direct feed or divide by eight
   assign pre_done = !cur.prescale_by_eight || (cur.pre_cnt == `FCS_PRESCALE_LAST);

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb
   begin
      rd_byte = 8'h00;
      unique case (idx)
         `FCS_IDX_TIMING_DIVIDER:
         begin
            rd_byte = {cur.divider_loaded_flag, cur.prescale_by_eight, cur.divider_value};
         end
         // (RQ7) readable, no write path
         `FCS_IDX_SECURITY_STATE:
         begin
            rd_byte = cur.security_state;
         end
         `FCS_IDX_MODULE_CONFIG:
         begin
            rd_byte = {cur.cmd_empty_ie, cur.cmd_done_ie, cur.key_write_access, 4'h0,
               cur.bank_select};
         end
         // (RQ14) banked copies picked by bank select
         `FCS_IDX_SECTOR_PROT:
         begin
            rd_byte = cur.sector_protection[cur.bank_select];
         end
         `FCS_IDX_COMMAND_CODE:
         begin
            rd_byte = cur.command_code[cur.bank_select];
         end
         default:
         begin
            rd_byte = 8'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_cur = cur;
      next_cur.osc_sync = {cur.osc_sync[1:0], osc_clk};
      next_cur.osc_level = next_level;
      next_cur.tick = 1'b0;

      // (RQ5) at most 8 x 64 = 512 osc edges per tick
      // (RQ16) ratio is prescale times divider plus one
      if (cur.divider_loaded_flag && osc_edge)
      begin
         next_cur.pre_cnt = pre_done ? 3'h0 : cur.pre_cnt + 3'h1;
         if (pre_done)
         begin
            if (cur.div_cnt == cur.divider_value)
            begin
               next_cur.div_cnt = 6'h00;
               next_cur.tick = 1'b1;
            end
            else
            begin
               next_cur.div_cnt = cur.div_cnt + 6'h01;
            end
         end
      end

      // (RQ1) flag only set by the first write
      // (RQ2) low seven bits are write once
      if (wr_divider && !cur.divider_loaded_flag)
      begin
         next_cur.divider_loaded_flag = 1'b1;
         next_cur.prescale_by_eight = pwdata[`FCS_DIV_PRESCALE_BIT];
         next_cur.divider_value = pwdata[5:0];
         next_cur.pre_cnt = 3'h0;
         next_cur.div_cnt = 6'h00;
      end

      // (RQ8) one-time load of the security byte after reset release
      if (!cur.load_done)
      begin
         next_cur.load_done = 1'b1;
         next_cur.security_state = nv_security_byte;
      end
      // (RQ11) unlock forces the field to unsecured
      else if (backdoor_unlock)
      begin
         next_cur.security_state[`FCS_SEC_FIELD_HI:`FCS_SEC_FIELD_LO] = `FCS_SEC_UNSECURED;
      end

      if (wr_config)
      begin
         next_cur.cmd_empty_ie = pwdata[`FCS_CFG_CMD_EMPTY_IE_BIT];
         next_cur.cmd_done_ie = pwdata[`FCS_CFG_CMD_DONE_IE_BIT];
         next_cur.bank_select = pwdata[`FCS_CFG_BANK_BIT];
         // (RQ15) key access gated by key enable
         if (key_on)
         begin
            next_cur.key_write_access = pwdata[`FCS_CFG_KEY_ACCESS_BIT];
         end
      end

      // (RQ14) write lands in the selected bank only
      if (wr_prot)
      begin
         next_cur.sector_protection[cur.bank_select] = pwdata[7:0];
      end
      if (wr_cmd)
      begin
         next_cur.command_code[cur.bank_select] = pwdata[7:0];
      end

      if (setup_phase)
      begin
         next_cur.prdata = {24'h000000, bad_addr ? 8'h00 : rd_byte};
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cur <= '0;
         cur.security_state <= `FCS_SECURITY_RESET;
         cur.sector_protection <= {`FCS_PROT_RESET, `FCS_PROT_RESET};
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign flash_timing_tick = cur.tick;
   assign divider_loaded = cur.divider_loaded_flag;
   assign backdoor_enabled = key_on;
   // (RQ10) only 10 reads as unsecured
   assign security_unsecured =
      (cur.security_state[`FCS_SEC_FIELD_HI:`FCS_SEC_FIELD_LO] == `FCS_SEC_UNSECURED);
   assign key_write_access = cur.key_write_access;
   assign cmd_empty_irq_en = cur.cmd_empty_ie;
   assign cmd_done_irq_en = cur.cmd_done_ie;
   assign bank_select = cur.bank_select;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // filtered osc edges since the last tick; an ignored divider write
   // must not restart it, or the ratio checks would see a short count
   logic [9:0] edges_since_tick;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         edges_since_tick <= 10'h000;
      end
      else if (wr_divider && !cur.divider_loaded_flag)
      begin
         edges_since_tick <= 10'h000;
      end
      else if (cur.tick)
      begin
         edges_since_tick <= osc_edge ? 10'h001 : 10'h000;
      end
      else if (osc_edge && edges_since_tick != 10'h3FF)
      begin
         edges_since_tick <= edges_since_tick + 10'h001;
      end
   end

   chk_loaded_rise: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
      $rose(cur.divider_loaded_flag) |-> $past(wr_divider))
      else $error("divider loaded flag rose without a divider write");
   chk_loaded_set: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
      wr_divider |=> cur.divider_loaded_flag ##1 cur.divider_loaded_flag)
      else $error("divider loaded flag not set after write");
   chk_div_once: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
      (wr_divider && cur.divider_loaded_flag) |=>
         $stable({cur.prescale_by_eight, cur.divider_value}))
      else $error("divider field changed on a second write");
   chk_direct_feed: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      (cur.divider_loaded_flag && !cur.prescale_by_eight && osc_edge && !wr_divider
         && cur.div_cnt == cur.divider_value) |=> cur.tick)
      else $error("direct feed missed its tick");
   chk_ratio_bound: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      cur.tick |-> edges_since_tick <= `FCS_MAX_RATIO)
      else $error("division ratio above 512");
   chk_sec_ro: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
      (wr_security && cur.load_done && !backdoor_unlock) |=> $stable(cur.security_state))
      else $error("security register changed on write");
   chk_nv_load: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
      !cur.load_done |=> cur.load_done && cur.security_state == $past(nv_security_byte))
      else $error("security byte not loaded after reset");
   chk_key_decode: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
      backdoor_enabled |-> cur.security_state[7:6] == 2'h2)
      else $error("backdoor enabled for wrong key code");
   chk_unlock_force: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
      (backdoor_unlock && cur.load_done) |=> security_unsecured)
      else $error("unlock did not unsecure");
   chk_unsecured_code: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
      security_unsecured |-> cur.security_state[1:0] == 2'h2)
      else $error("unsecured reported for wrong code");
   chk_key_write_access_gate: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
      (wr_config && !key_on) |=> $stable(cur.key_write_access))
      else $error("key access written while disabled");
   chk_bank_copy: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
      (wr_prot && !cur.bank_select) |=> $stable(cur.sector_protection[1]))
      else $error("unselected bank copy changed");

   // ----------------------------------------------------------------
   // checks: timing chain
   // ----------------------------------------------------------------
   chk_loaded_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
      cur.divider_loaded_flag |=> cur.divider_loaded_flag)
      else $error("divider loaded flag dropped");
   chk_div_first: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
      (wr_divider && !cur.divider_loaded_flag) |=>
         {cur.prescale_by_eight, cur.divider_value} == $past(pwdata[6:0]))
      else $error("first divider write not taken");
   chk_count_restart: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      (wr_divider && !cur.divider_loaded_flag) |=>
         cur.pre_cnt == 3'h0 && cur.div_cnt == 6'h00)
      else $error("counters not restarted by first divider write");
   chk_pre_idle: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      !cur.prescale_by_eight |-> cur.pre_cnt == 3'h0)
      else $error("prescaler counted while bypassed");
   chk_prescale_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      (cur.divider_loaded_flag && cur.prescale_by_eight && osc_edge
         && cur.pre_cnt != `FCS_PRESCALE_LAST) |=> $stable(cur.div_cnt) && !cur.tick)
      else $error("divider advanced before eighth edge");
   chk_prescale_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      (cur.divider_loaded_flag && cur.prescale_by_eight && osc_edge
         && cur.pre_cnt == `FCS_PRESCALE_LAST) |=> cur.pre_cnt == 3'h0)
      else $error("prescaler did not wrap after eight edges");
   chk_div_cap: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      cur.div_cnt <= cur.divider_value)
      else $error("divider count beyond its end value");
   chk_ratio_exact: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
      cur.tick |-> edges_since_tick ==
         (cur.prescale_by_eight ? 10'h008 : 10'h001) * ({4'h0, cur.divider_value} + 10'h001))
      else $error("tick period differs from programmed ratio");
   chk_tick_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      cur.tick |=> !cur.tick)
      else $error("timing tick longer than one cycle");
   chk_idle_unloaded: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      !cur.divider_loaded_flag |-> !cur.tick)
      else $error("timing tick before divider was written");

   // ----------------------------------------------------------------
   // checks: security, configuration and banks
   // ----------------------------------------------------------------
   chk_unlock_keep: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
      (backdoor_unlock && cur.load_done) |=>
         cur.security_state[7:2] == $past(cur.security_state[7:2]))
      else $error("unlock touched bits outside the security field");
   chk_key_write_access_take: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
      (wr_config && key_on) |=>
         cur.key_write_access == $past(pwdata[`FCS_CFG_KEY_ACCESS_BIT]))
      else $error("key access write lost while enabled");
   chk_bank_take: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
      wr_config |=> cur.bank_select == $past(pwdata[`FCS_CFG_BANK_BIT]))
      else $error("bank select not taken from config write");
   chk_prot_keep: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
      (wr_prot && cur.bank_select) |=> $stable(cur.sector_protection[0]))
      else $error("protection copy of bank zero changed");
   chk_cmd_keep: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
      (wr_cmd && cur.bank_select) |=> $stable(cur.command_code[0]))
      else $error("command copy of bank zero changed");

endmodule

// ===== testbench/flash_clock_security_regs_tb.sv
// self-checking bench for the flash clock divider and security register bank
`timescale 1ns/1ps
`include "fcs_defs.svh"

module flash_clock_security_regs_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic osc_clk = 1'b0;
   logic [7:0] nv_security_byte = 8'hFF;
   logic backdoor_unlock = 1'b0;
   logic flash_timing_tick, divider_loaded, backdoor_enabled, security_unsecured;
   logic key_write_access, cmd_empty_irq_en, cmd_done_irq_en, bank_select;
   logic [1:0] osc_cnt = 2'h0;
   logic [31:0] rd;
   logic er;
   int err_count = 0;
   int check_count = 0;

   fcs_regs #(.ADDR_W(8)) fcs_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .osc_clk(osc_clk),
      .nv_security_byte(nv_security_byte), .backdoor_unlock(backdoor_unlock),
      .flash_timing_tick(flash_timing_tick), .divider_loaded(divider_loaded),
      .backdoor_enabled(backdoor_enabled), .security_unsecured(security_unsecured),
      .key_write_access(key_write_access), .cmd_empty_irq_en(cmd_empty_irq_en),
      .cmd_done_irq_en(cmd_done_irq_en), .bank_select(bank_select));

   always #50 pclk = ~pclk;

   // oscillator at a quarter of the bus rate, slow enough for the pin filter
   always @(posedge pclk)
   begin
      osc_cnt <= osc_cnt + 2'h1;
      if (osc_cnt[0])
         osc_clk <= ~osc_clk;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic do_reset(input logic [7:0] nv);
      @(posedge pclk);
      presetn <= 1'b0;
      nv_security_byte <= nv;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   // one transfer: setup, access held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      bit ok;
      ok = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n < 50 && !ok; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
         begin
            ok = 1;
            rd = prdata;
            er = pslverr;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // outputs launched by the access edge are read once settled
      @(negedge pclk);
      if (!ok)
      begin
         err_count++;
         wrap_up();
      end
   endtask

   function automatic logic [7:0] ad(input logic [3:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   task automatic tick_gap(output int gap);
      bit seen;
      gap = 0;
      for (int k = 0; k < 2; k++)
      begin
         seen = 0;
         for (int n = 0; n < 5000 && !seen; n++)
         begin
            @(posedge pclk);
            gap++;
            seen = (flash_timing_tick === 1'b1);
         end
         if (!seen)
         begin
            err_count++;
            wrap_up();
         end
         if (k == 0)
            gap = 0;
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_security();
      logic [7:0] nv;
      for (int i = 0; i < 4; i++)
      begin
         nv = {i[1:0], 4'hF, i[1:0]};
         do_reset(nv);
         apb(1'b0, ad(`FCS_IDX_SECURITY_STATE), 8'h00);
         check(rd, {24'h0, nv});
         check(backdoor_enabled, i == 2);
         check(security_unsecured, i == 2);
         apb(1'b1, ad(`FCS_IDX_SECURITY_STATE), ~nv);
         apb(1'b0, ad(`FCS_IDX_SECURITY_STATE), 8'h00);
         check(rd, {24'h0, nv});
      end
      $display("test security done");
   endtask

   task automatic t_ratio(input logic [7:0] val);
      int gap;
      do_reset(8'hFF);
      apb(1'b0, ad(`FCS_IDX_TIMING_DIVIDER), 8'h00);
      check(rd[7], 1'b0);
      check(divider_loaded, 1'b0);
      apb(1'b1, ad(`FCS_IDX_TIMING_DIVIDER), val);
      apb(1'b1, ad(`FCS_IDX_TIMING_DIVIDER), ~val);
      apb(1'b0, ad(`FCS_IDX_TIMING_DIVIDER), 8'h00);
      check(rd, {24'h0, 1'b1, val[6:0]});
      check(divider_loaded, 1'b1);
      tick_gap(gap);
      check(gap, 4 * (val[6] ? 8 : 1) * (val[5:0] + 1));
      $display("test ratio %h done", val);
   endtask

   task automatic t_unlock();
      do_reset(8'hBF);
      check(security_unsecured, 1'b0);
      apb(1'b1, ad(`FCS_IDX_MODULE_CONFIG), 8'h20);
      check(key_write_access, 1'b1);
      @(posedge pclk);
      backdoor_unlock <= 1'b1;
      @(posedge pclk);
      backdoor_unlock <= 1'b0;
      @(posedge pclk);
      check(security_unsecured, 1'b1);
      apb(1'b0, ad(`FCS_IDX_SECURITY_STATE), 8'h00);
      check(rd, 32'hBE);
      do_reset(8'h7D);
      apb(1'b1, ad(`FCS_IDX_MODULE_CONFIG), 8'hFF);
      check({cmd_empty_irq_en, cmd_done_irq_en, key_write_access, bank_select}, 4'hD);
      apb(1'b0, ad(`FCS_IDX_MODULE_CONFIG), 8'h00);
      check(rd, 32'hC1);
      $display("test unlock done");
   endtask

   task automatic t_banks();
      do_reset(8'hFF);
      apb(1'b1, ad(`FCS_IDX_TIMING_DIVIDER), 8'h09);
      apb(1'b1, ad(`FCS_IDX_SECTOR_PROT), 8'h12);
      apb(1'b1, ad(`FCS_IDX_MODULE_CONFIG), 8'h01);
      check(bank_select, 1'b1);
      apb(1'b0, ad(`FCS_IDX_SECTOR_PROT), 8'h00);
      check(rd, 32'hFF);
      apb(1'b1, ad(`FCS_IDX_SECTOR_PROT), 8'h34);
      apb(1'b1, ad(`FCS_IDX_COMMAND_CODE), 8'h56);
      apb(1'b0, ad(`FCS_IDX_TIMING_DIVIDER), 8'h00);
      check(rd, 32'h89);
      apb(1'b1, ad(`FCS_IDX_MODULE_CONFIG), 8'h00);
      apb(1'b0, ad(`FCS_IDX_SECTOR_PROT), 8'h00);
      check(rd, 32'h12);
      apb(1'b0, ad(`FCS_IDX_COMMAND_CODE), 8'h00);
      check(rd, 32'h00);
      apb(1'b1, ad(`FCS_IDX_MODULE_CONFIG), 8'h01);
      apb(1'b0, ad(`FCS_IDX_COMMAND_CODE), 8'h00);
      check(rd, 32'h56);
      apb(1'b0, ad(4'hC), 8'h00);
      check(rd, 32'h0);
      check(er, 1'b0);
      apb(1'b1, 8'h41, 8'h55);
      check(er, 1'b1);
      apb(1'b0, 8'h40, 8'h00);
      check(rd, 32'h0);
      check(er, 1'b1);
      $display("test banks done");
   endtask

   initial
   begin
      t_security();
      t_ratio(8'h03);
      t_ratio(8'h41);
      t_ratio(8'h7F);
      // 2.5 MHz oscillator over 16 gives 156 kHz, inside the legal band
      t_ratio(8'h0F);
      t_unlock();
      t_banks();
      wrap_up();
   end
endmodule
